// *** mode_pkg.sv ***
// constants for the main mode word and self-refresh logic
// Overview of operation
// - loop disabled entering self refresh, re-enabled and reset on exit
// - self refresh keeps array valid using internal refresh timing only
// - mode word held until next load; reprogramming keeps array contents
// - bits 0 to 2 give burst size four or eight, reads and writes
// - burst wraps inside aligned block of burst size; low bits give start
// - bit 3 picks sequential or interleaved column order
// - sequential counts low two bits modulo four, nibble order repeated
// - interleaved index is start low bits xor beat count
// - test select bit one loads nothing else; controller never sets it (the bench sets it through the controller model with load 17'h01F87)
// - loop reset bit one fires loop reset, then clears itself
// - bits 9 to 11 give recovery 2 to 8 clocks before auto precharge
// - exit speed bit picks fast or slow active power-down exit
// - bits 4 to 6 give read latency setting 3 to 7 clocks
// - with no additive latency, first data at edge n plus m
// - with additive latency, read held internally that many clocks
// - additive latency 0 to 6; read = additive + setting; write one less
// - bank address selects the mode word, address carries the fields
`default_nettype none
package mode_pkg;
  localparam int          WORD_W       = 17;
  localparam int          COL_W        = 10;
  localparam int          PIPE_DEPTH   = 32;
  localparam int          DLY_W        = 5;
  localparam int          BURST_LSB    = 0;
  localparam int          TYPE_BIT     = 3;
  localparam int          LAT_LSB      = 4;
  localparam int          TEST_BIT     = 7;
  localparam int          LOOP_RST_BIT = 8;
  localparam int          WR_LSB       = 9;
  localparam int          EXIT_BIT     = 12;
  localparam int          AP_BIT       = 10;
  localparam logic [2:0]  BURST_FOUR   = 3'h2;
  localparam logic [2:0]  BURST_EIGHT  = 3'h3;
  localparam logic [1:0]  MAIN_SELECT  = 2'h0;
  localparam logic [16:0] WORD_RESET   = 17'h00000;
  // command encodings: ras_n, cas_n, we_n
  localparam logic [2:0]  CMD_LOAD     = 3'h0;
  localparam logic [2:0]  CMD_REFRESH  = 3'h1;
  localparam logic [2:0]  CMD_READ     = 3'h5;
  localparam logic [2:0]  CMD_WRITE    = 3'h4;
  localparam int          CLK_NS       = 20;
  localparam int          REFRESH_NS   = 7800;
  localparam int          REFRESH_CYC  = REFRESH_NS / CLK_NS;
endpackage : mode_pkg
`default_nettype wire

// *** burst_if.sv ***
// start column, beat and burst settings shared with the order logic
`timescale 1ns/1ps
`default_nettype none
interface burst_if;
  logic [2:0] start;
  logic [2:0] beat;
  logic       eight;
  logic       interleaved;
  logic [2:0] col;
  modport ctrl  (output start, output beat, output eight,
                 output interleaved, input col);
  modport order (input start, input beat, input eight,
                 input interleaved, output col);
endinterface : burst_if
`default_nettype wire

// *** burst_order.sv ***
// column order within one burst
`timescale 1ns/1ps
`default_nettype none
module burst_order (
  burst_if.order b
);
  logic [1:0] low;

  always_comb begin
    // sequential wraps the low two bits inside the nibble and flips bit 2 after four beats, interleaved xors all three start bits with the beat count
    low = b.start[1:0] + b.beat[1:0];
    if (b.interleaved) begin
      b.col = b.start ^ b.beat;
    end else begin
      b.col = {b.start[2] ^ b.beat[2], low};
    end
    if (!b.eight) begin
      b.col[2] = 1'b0;
    end
  end
endmodule : burst_order
`default_nettype wire

// *** delay_pipe.sv ***
// event pipe with a run-time selected delay
`timescale 1ns/1ps
`default_nettype none
module delay_pipe #(
  parameter int W     = 4,
  parameter int DEPTH = 32,
  parameter int DW    = 5
) (
  input  wire logic          mclk_in,
  input  wire logic          reset_in,
  input  wire logic          push_in,
  input  wire logic [W-1:0]  data_in,
  input  wire logic [DW-1:0] delay_in,
  output logic               pop_out,
  output logic [W-1:0]       data_out
);
  logic [DEPTH-1:0] vld_q;
  logic [W-1:0]     dat_q [DEPTH];
  logic [DW-1:0]    tap;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      vld_q <= '0;
    end else begin
      vld_q <= {vld_q[DEPTH-2:0], push_in};
    end
  end

  always_ff @(posedge mclk_in) begin
    dat_q[0] <= data_in;
    for (int i = 1; i < DEPTH; i++) begin
      dat_q[i] <= dat_q[i-1];
    end
  end

  // tap one short: the caller registers the result
  always_comb begin
    tap      = delay_in - DW'(1);
    pop_out  = vld_q[tap];
    data_out = dat_q[tap];
  end
endmodule : delay_pipe
`default_nettype wire

// *** mode_ctrl.sv ***
// main mode word, burst order, latencies and self refresh
`timescale 1ns/1ps
`default_nettype none
module mode_ctrl #(
  parameter int REFRESH_CYC = mode_pkg::REFRESH_CYC
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        cke_in,
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic [2:0]  ba_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [2:0]  additive_latency_in,
  output logic [16:0]      main_mode_word_out,
  output logic             test_mode_out,
  output logic             exit_slow_out,
  output logic             loop_enable_out,
  output logic             loop_reset_out,
  output logic             self_refresh_out,
  output logic             refresh_pulse_out,
  output logic             read_data_out,
  output logic [9:0]       read_col_out,
  output logic             precharge_out,
  output logic [2:0]       precharge_bank_out
);
  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_ACTIVE = 1'b0,
    ST_SELF   = 1'b1
  } pwr_e;

  logic [2:0]  cmd;
  logic        sel;
  logic        load_cmd;
  logic        ref_cmd;
  logic        rd_cmd;
  logic        wr_cmd;

  assign cmd = {ras_n_in, cas_n_in, we_n_in};
  assign sel = !cs_n_in;
  // bank address picks the main word
  assign load_cmd = sel && cmd == mode_pkg::CMD_LOAD &&
                    ba_in[1:0] == mode_pkg::MAIN_SELECT;
  assign ref_cmd  = sel && cmd == mode_pkg::CMD_REFRESH;
  assign rd_cmd   = sel && cmd == mode_pkg::CMD_READ;
  assign wr_cmd   = sel && cmd == mode_pkg::CMD_WRITE;

  // ----------------------------------------------------------------
  // mode word
  // ----------------------------------------------------------------
  logic [16:0] word_q;
  logic        test_q;
  logic        loop_rst_q;
  pwr_e        pwr_q;
  logic        sr_exit;

  // whole word replaced on each load with the test bit clear and kept until the next
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      word_q <= mode_pkg::WORD_RESET;
      test_q <= 1'b0;
    end else if (load_cmd) begin
      test_q <= addr_in[mode_pkg::TEST_BIT];
      if (!addr_in[mode_pkg::TEST_BIT]) begin
        word_q <= {ba_in[2], addr_in};
        // the loop reset bit never stays set
        word_q[mode_pkg::LOOP_RST_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // decoded fields
  // ----------------------------------------------------------------
  logic        eight;
  logic        interleaved;
  logic [2:0]  lat_set;
  logic [3:0]  rec;
  logic [3:0]  rd_lat;
  logic [3:0]  wr_lat;
  logic [2:0]  half_burst;

  assign eight = word_q[mode_pkg::BURST_LSB +: 3] ==
                 mode_pkg::BURST_EIGHT;
  assign interleaved = word_q[mode_pkg::TYPE_BIT];
  assign lat_set = word_q[mode_pkg::LAT_LSB +: 3];
  assign rec = {1'b0, word_q[mode_pkg::WR_LSB +: 3]} + 4'h1;
  assign rd_lat = {1'b0, additive_latency_in} +
                  {1'b0, lat_set};
  assign wr_lat = rd_lat - 4'h1;
  assign half_burst = eight ? 3'h4 : 3'h2;

  // ----------------------------------------------------------------
  // loop control and self refresh
  // ----------------------------------------------------------------
  logic        loop_en_q;
  logic [15:0] ref_cnt_q;
  logic        ref_pulse_q;

  assign sr_exit = pwr_q == ST_SELF && cke_in;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pwr_q <= ST_ACTIVE;
    end else begin
      case (pwr_q)
        ST_ACTIVE: begin
          if (ref_cmd && !cke_in) begin
            pwr_q <= ST_SELF;
          end
        end
        ST_SELF: begin
          if (cke_in) begin
            pwr_q <= ST_ACTIVE;
          end
        end
        default: pwr_q <= ST_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      loop_en_q <= 1'b1;
    end else if (pwr_q == ST_ACTIVE && ref_cmd && !cke_in) begin
      loop_en_q <= 1'b0;
    end else if (sr_exit) begin
      loop_en_q <= 1'b1;
    end
  end

  // one pulse per load with the bit set and the test bit clear, and per self refresh exit
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      loop_rst_q <= 1'b0;
    end else begin
      loop_rst_q <= (load_cmd && !addr_in[mode_pkg::TEST_BIT] &&
                     addr_in[mode_pkg::LOOP_RST_BIT]) ||
                    sr_exit;
    end
  end

  // internal timer, no edge from the controller needed
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ref_cnt_q   <= 16'h0000;
      ref_pulse_q <= 1'b0;
    end else if (pwr_q == ST_SELF &&
                 ref_cnt_q == 16'(REFRESH_CYC - 1)) begin
      ref_cnt_q   <= 16'h0000;
      ref_pulse_q <= 1'b1;
    end else begin
      ref_cnt_q   <= pwr_q == ST_SELF ? ref_cnt_q + 16'h0001
                                      : 16'h0000;
      ref_pulse_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic             rd_pop;
  logic [9:0]       rd_col;
  logic [9:0]       blk_q;
  logic [2:0]       start_q;
  logic [2:0]       beat_q;
  logic             busy_q;
  logic             rd_q;
  logic [9:0]       col_q;
  logic             go;

  // additive latency folded into the delay: command held internally
  delay_pipe #(
    .W     (mode_pkg::COL_W),
    .DEPTH (mode_pkg::PIPE_DEPTH),
    .DW    (mode_pkg::DLY_W)
  ) u_rd (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .push_in  (rd_cmd && pwr_q == ST_ACTIVE),
    .data_in  (addr_in[9:0]),
    .delay_in ({1'b0, rd_lat}),
    .pop_out  (rd_pop),
    .data_out (rd_col)
  );

  burst_if bi ();
  assign go             = rd_pop;
  assign bi.start       = go ? rd_col[2:0] : start_q;
  assign bi.beat        = go ? 3'h0 : beat_q;
  assign bi.eight       = eight;
  assign bi.interleaved = interleaved;

  burst_order u_order (
    .b (bi)
  );

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      busy_q  <= 1'b0;
      beat_q  <= 3'h0;
      start_q <= 3'h0;
      blk_q   <= 10'h000;
    end else if (go) begin
      // a new read restarts the burst, as a burst interrupt would
      busy_q  <= 1'b1;
      beat_q  <= 3'h1;
      start_q <= rd_col[2:0];
      blk_q   <= eight ? {rd_col[9:3], 3'h0}
                       : {rd_col[9:2], 2'h0};
    end else if (busy_q) begin
      beat_q <= beat_q + 3'h1;
      if (beat_q == (eight ? 3'h7 : 3'h3)) begin
        busy_q <= 1'b0;
      end
    end
  end

  // first beat lands at edge n plus read latency
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rd_q  <= 1'b0;
      col_q <= 10'h000;
    end else begin
      rd_q  <= go || busy_q;
      // block of the new read, so a length four start keeps column bit 2
      col_q <= go ? ((eight ? {rd_col[9:3], 3'h0}
                            : {rd_col[9:2], 2'h0}) |
                     {7'h00, bi.col})
                  : (blk_q | {7'h00, bi.col});
    end
  end

  // ----------------------------------------------------------------
  // write with auto precharge
  // ----------------------------------------------------------------
  logic       pre_pop;
  logic [2:0] pre_bank;
  logic       pre_q;
  logic [2:0] pre_bank_q;
  logic [4:0] pre_dly;

  // last data beat at write latency plus half the burst, then recovery
  assign pre_dly = 5'(wr_lat) + 5'(half_burst) + 5'(rec);

  delay_pipe #(
    .W     (3),
    .DEPTH (mode_pkg::PIPE_DEPTH),
    .DW    (mode_pkg::DLY_W)
  ) u_wr (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .push_in  (wr_cmd && addr_in[mode_pkg::AP_BIT] &&
               pwr_q == ST_ACTIVE),
    .data_in  (ba_in),
    .delay_in (pre_dly),
    .pop_out  (pre_pop),
    .data_out (pre_bank)
  );

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pre_q      <= 1'b0;
      pre_bank_q <= 3'h0;
    end else begin
      pre_q      <= pre_pop;
      pre_bank_q <= pre_bank;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign main_mode_word_out = word_q;
  assign test_mode_out      = test_q;
  // only steers active power-down exit, not precharge power-down
  assign exit_slow_out      = word_q[mode_pkg::EXIT_BIT];
  assign loop_enable_out    = loop_en_q;
  assign loop_reset_out     = loop_rst_q;
  assign self_refresh_out   = pwr_q == ST_SELF;
  assign refresh_pulse_out  = ref_pulse_q;
  assign read_data_out      = rd_q;
  assign read_col_out       = col_q;
  assign precharge_out      = pre_q;
  assign precharge_bank_out = pre_bank_q;
endmodule : mode_ctrl
`default_nettype wire

// *** mode_pkg_unused_guard.sv ***
// intentionally empty companion: no content
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** ddr_ctrl_model.sv ***
// controller-side command driver facing the mode logic
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model (
  input  wire logic  mclk_in,
  output logic        cke_out,
  output logic        cs_n_out,
  output logic [2:0]  cmd_out,
  output logic [2:0]  ba_out,
  output logic [15:0] addr_out
);
  int since_rst = 999;
  initial begin
    cke_out  = 1'b1;
    cs_n_out = 1'b1;
    cmd_out  = 3'h7;
    ba_out   = 3'h0;
    addr_out = 16'h0000;
  end
  always @(posedge mclk_in) since_rst <= since_rst + 1;
  // one command for one edge, then a nop; caller sits just after an edge
  task automatic send(input logic [2:0] c, input logic [2:0] b,
                      input logic [15:0] a, input logic k);
    if (c == mode_pkg::CMD_READ)
      while (since_rst < 200) @(posedge mclk_in) #1;
    if (k && !cke_out) since_rst = 0;
    cs_n_out = 1'b0;
    cmd_out  = c;
    ba_out   = b;
    addr_out = a;
    cke_out  = k;
    @(posedge mclk_in) #1;
    if (c == mode_pkg::CMD_LOAD && a[8]) since_rst = 0;
    // idle lines show the inverse so a stale value never passes
    cmd_out  = 3'h7;
    addr_out = ~a;
    ba_out   = ~b;
  endtask : send
endmodule : ddr_ctrl_model
`default_nettype wire

// *** mode_ctrl_asserts.sv ***
// port checks for the mode word and self refresh logic
`timescale 1ns/1ps
`default_nettype none
module mode_ctrl_asserts (
  input wire logic        mclk_in, reset_in, cke_in, cs_n_in,
  input wire logic        ras_n_in, cas_n_in, we_n_in,
  input wire logic [2:0]  ba_in, additive_latency_in, precharge_bank_out,
  input wire logic [15:0] addr_in,
  input wire logic [16:0] main_mode_word_out,
  input wire logic        test_mode_out, exit_slow_out, loop_enable_out,
  input wire logic        loop_reset_out, self_refresh_out,
  input wire logic        refresh_pulse_out, read_data_out, precharge_out,
  input wire logic [9:0]  read_col_out
);
  logic [16:0] load_word;
  assign load_word = {ba_in[2], addr_in[15:9], 1'b0, addr_in[7:0]};
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // ------------------------------
  // command sequences
  // ------------------------------
  sequence load_s;
    !cs_n_in && !ras_n_in && !cas_n_in && !we_n_in && ba_in[1:0] == 2'h0;
  endsequence
  sequence sr_enter_s;
    !cs_n_in && !ras_n_in && !cas_n_in && we_n_in && !cke_in
      && !self_refresh_out;
  endsequence
  sequence sr_exit_s;
    self_refresh_out && cke_in;
  endsequence
  // ------------------------------
  // checks
  // ------------------------------
  chk_load_word: assert property (
    load_s ##0 !addr_in[7] |=> main_mode_word_out == $past(load_word))
    else $error("mode word not loaded");
  chk_loop_reset: assert property (
    load_s ##0 addr_in[8] && !addr_in[7] |=> loop_reset_out)
    else $error("loop reset pulse missing");
  chk_test_guard: assert property (
    load_s ##0 addr_in[7] |=> test_mode_out && $stable(main_mode_word_out))
    else $error("test load changed the word");
  chk_self_clear: assert property (
    main_mode_word_out[8] == 1'b0)
    else $error("loop reset bit stuck");
  chk_sr_enter: assert property (
    sr_enter_s |=> self_refresh_out && !loop_enable_out)
    else $error("self refresh entry wrong");
  chk_sr_exit: assert property (
    sr_exit_s |=> !self_refresh_out && loop_enable_out && loop_reset_out)
    else $error("self refresh exit wrong");
  chk_exit_speed: assert property (
    load_s ##0 !addr_in[7] |=> exit_slow_out == $past(addr_in[12]))
    else $error("exit speed differs from loaded bit");
  chk_refresh_inside: assert property (
    refresh_pulse_out |-> self_refresh_out || $past(self_refresh_out))
    else $error("refresh pulse outside self refresh");
endmodule : mode_ctrl_asserts
bind mode_ctrl mode_ctrl_asserts u_chk (.mclk_in, .reset_in, .cke_in,
  .cs_n_in, .ras_n_in, .cas_n_in, .we_n_in, .ba_in, .additive_latency_in,
  .precharge_bank_out, .addr_in, .main_mode_word_out, .test_mode_out,
  .exit_slow_out, .loop_enable_out, .loop_reset_out, .self_refresh_out,
  .refresh_pulse_out, .read_data_out, .precharge_out, .read_col_out);
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the mode word and self refresh logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int RCYC = 8;
  logic        mclk_in, reset_in, cke_in, cs_n_in, test_mode_out;
  logic        exit_slow_out, loop_enable_out, loop_reset_out;
  logic        self_refresh_out, refresh_pulse_out;
  logic        read_data_out, precharge_out;
  logic [2:0]  cmd, ba_in, additive_latency_in, precharge_bank_out;
  logic [15:0] addr_in;
  logic [16:0] main_mode_word_out, exp_word, w;
  logic [9:0]  read_col_out;
  logic [31:0] r;
  int          n_fail = 0, check_count = 0, seed = 22354, al_v = 0;
  int          bl, cl, n, m, twr;
  ddr_ctrl_model ctl (.mclk_in, .cke_out(cke_in), .cs_n_out(cs_n_in),
    .cmd_out(cmd), .ba_out(ba_in), .addr_out(addr_in));
  mode_ctrl #(.REFRESH_CYC(RCYC)) DUT (.mclk_in, .reset_in, .cke_in,
    .cs_n_in, .ras_n_in(cmd[2]), .cas_n_in(cmd[1]), .we_n_in(cmd[0]),
    .ba_in, .addr_in, .additive_latency_in, .main_mode_word_out,
    .test_mode_out, .exit_slow_out, .loop_enable_out, .loop_reset_out,
    .self_refresh_out, .refresh_pulse_out, .read_data_out, .read_col_out,
    .precharge_out, .precharge_bank_out);
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  // ------------------------------
  // reference model and helpers
  // ------------------------------
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  function automatic logic [9:0] exp_col(logic [9:0] s, int k, int b,
                                         logic il);
    int lo;
    if (il) lo = (s ^ k) & (b - 1);
    else lo = ((s + k) & 3) | ((s ^ k) & 4 & (b - 1));
    return 10'((s & ~(b - 1)) | lo);
  endfunction : exp_col
  task automatic load(input logic [16:0] v);
    ctl.send(mode_pkg::CMD_LOAD, {v[16], 2'h0}, v[15:0], 1'b1);
    if (!v[7]) exp_word = v & ~17'h00100;
    check(loop_reset_out, v[8] & ~v[7]);
    check(main_mode_word_out, exp_word);
    check(test_mode_out, v[7]);
    check(exit_slow_out, exp_word[12]);
    @(posedge mclk_in) #1;
    check(loop_reset_out, 1'b0);
    repeat (2) @(posedge mclk_in) #1;
    bl = (exp_word[2:0] == mode_pkg::BURST_EIGHT) ? 8 : 4;
    cl = exp_word[6:4];
  endtask : load
  // latency counted from the taking edge to the first beat
  task automatic read(input logic [9:0] c);
    int i;
    ctl.send(mode_pkg::CMD_READ, 3'h1, {6'h00, c}, 1'b1);
    i = 0;
    while (read_data_out !== 1'b1 && i < 40) begin
      @(posedge mclk_in) #1;
      i++;
    end
    check(i, al_v + cl);
    for (int k = 0; k < bl; k++) begin
      check(read_col_out, exp_col(c, k, bl, exp_word[3]));
      check(read_data_out, 1'b1);
      @(posedge mclk_in) #1;
    end
    check(read_data_out, 1'b0);
  endtask : read
  task automatic write_ap(input logic [2:0] b);
    int i;
    ctl.send(mode_pkg::CMD_WRITE, b, 16'h0400, 1'b1);
    i = 0;
    while (precharge_out !== 1'b1 && i < 60) begin
      @(posedge mclk_in) #1;
      i++;
    end
    check(i, al_v + cl + bl / 2 + exp_word[11:9]);
    check(precharge_bank_out, b);
  endtask : write_ap
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    reset_in = 1'b1;
    additive_latency_in = 3'h0;
    repeat (5) @(posedge mclk_in);
    #1 reset_in = 1'b0;
    check(main_mode_word_out, mode_pkg::WORD_RESET);
    check(loop_enable_out, 1'b1);
    check(self_refresh_out, 1'b0);
    $display("reset test done");
    for (int t = 0; t < 8; t++) begin
      r = $random(seed);
      // recovery time 21 to 141 ns, rounded up to whole clocks
      twr = (21 + (r[15:13] % 7) * 20 + mode_pkg::CLK_NS - 1) /
            mode_pkg::CLK_NS;
      w = {4'h0, r[12], 3'(twr - 1), r[8], 1'b0,
           3'(3 + r[6:4] % 5), r[3], 3'(2 + t % 2)};
      al_v = r[20:18] % 7;
      additive_latency_in = 3'(al_v);
      load(w);
      read(r[31:22]);
      read(10'(r[27:18] ^ 10'h2A5));
      write_ap(r[18:16]);
    end
    $display("mode word test done");
    load(17'h01F87);
    read(10'h3F1);
    load(17'h00632);
    ctl.send(mode_pkg::CMD_LOAD, 3'h1, 16'h0005, 1'b1);
    repeat (2) @(posedge mclk_in) #1;
    check(main_mode_word_out, exp_word);
    $display("test mode test done");
    ctl.send(mode_pkg::CMD_REFRESH, 3'h0, 16'h0000, 1'b0);
    check(self_refresh_out, 1'b1);
    check(loop_enable_out, 1'b0);
    @(posedge mclk_in) #1;
    ctl.send(mode_pkg::CMD_READ, 3'h0, 16'h0005, 1'b0);
    n = 0;
    m = 0;
    repeat (2 * RCYC) begin
      @(posedge mclk_in) #1;
      n += refresh_pulse_out;
      m += read_data_out;
    end
    check(n, 2);
    check(m, 0);
    ctl.send(3'h7, 3'h0, 16'h0000, 1'b1);
    check(self_refresh_out, 1'b0);
    check(loop_enable_out, 1'b1);
    check(loop_reset_out, 1'b1);
    check(main_mode_word_out, exp_word);
    $display("self refresh test done");
    wrap_up();
  end
  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
